// >>> bench/sifb_checker.sv
// assertion checker for the identification frame builder
`timescale 1ns/10ps
module sifb_checker (
  input wire i_clk,
  input wire i_nrst,
  input wire i_in_connection,
  input wire i_tx_ready,
  input wire i_break_rx,
  input wire i_pwr_grant_rx,
  input wire i_in_low_power,
  input wire o_tx_valid,
  input wire [31:0] o_tx_data,
  input wire o_tx_sof,
  input wire o_tx_eof,
  input wire o_id_timeout,
  input wire o_cominit_req,
  input wire o_break_reply_tx,
  input wire o_pwr_req_tx,
  input wire o_pwr_ack_tx,
  input wire o_slumber_en,
  input wire o_partial_en,
  input wire o_com_only
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);
  // frame start, head and end, and the timeout pair
  chk_head_word: assert property (
    o_tx_sof |-> o_tx_data[31:24] == 8'h10 && o_tx_data[15:0] == 16'h0008)
    else $error("bad head word");
  chk_no_conn: assert property (
    $rose(o_tx_valid) |-> !$past(i_in_connection)) else $error("in conn");
  chk_frame_end: assert property (
    o_tx_eof && o_tx_valid && i_tx_ready |=> !o_tx_valid)
    else $error("frame too long");
  chk_timeout_pair: assert property (
    o_id_timeout |-> o_cominit_req) else $error("no cominit");
  // primitive answers and power states
  chk_break_reply: assert property (
    i_break_rx |=> o_break_reply_tx) else $error("break unanswered");
  chk_grant_ack: assert property (
    o_pwr_ack_tx |-> $past(i_pwr_grant_rx)) else $error("stray ack");
  chk_lp_held: assert property (
    o_pwr_req_tx |-> !o_slumber_en && !o_partial_en
      && !$past(i_in_low_power)) else $error("req in low power");
  chk_com_only: assert property (
    o_com_only == i_in_low_power) else $error("com only wrong");
endmodule
bind sifb_frame_builder sifb_checker u_chk (.i_clk, .i_nrst,
  .i_in_connection, .i_tx_ready, .i_break_rx, .i_pwr_grant_rx,
  .i_in_low_power, .o_tx_valid, .o_tx_data, .o_tx_sof, .o_tx_eof,
  .o_id_timeout, .o_cominit_req, .o_break_reply_tx, .o_pwr_req_tx,
  .o_pwr_ack_tx, .o_slumber_en, .o_partial_en, .o_com_only);

// >>> bench/sifb_far_model.sv
// far side model: frame sink, identify sender, power source
`timescale 1ns/10ps
module sifb_far_model (
  input wire i_clk,
  input wire i_nrst,
  input wire i_stall,
  input wire i_answer,
  input wire i_tx_valid,
  input wire [31:0] i_tx_data,
  input wire i_tx_eof,
  input wire i_pwr_req,
  output reg o_ready,
  output reg o_far_identify,
  output reg o_grant
);
  reg [31:0] words [0:7];
  reg [2:0] idx;
  reg [2:0] id_cnt;
  reg [1:0] gnt_cnt;
  // sink pauses every other cycle when stalling; identify and grant
  // are sent a few cycles late so the device sees a slow partner
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_ready <= 1'b0;
      idx <= 3'h0;
      id_cnt <= 3'h0;
      gnt_cnt <= 2'h0;
      o_far_identify <= 1'b0;
      o_grant <= 1'b0;
    end else begin
      o_ready <= !i_stall || !o_ready;
      if (i_tx_valid && o_ready) begin
        words[idx] <= i_tx_data;
        idx <= i_tx_eof ? 3'h0 : idx + 3'h1;
      end
      o_far_identify <= (id_cnt == 3'h1);
      if (i_tx_valid && o_ready && i_tx_eof && i_answer)
        id_cnt <= 3'h3;
      else if (id_cnt != 3'h0)
        id_cnt <= id_cnt - 3'h1;
      o_grant <= (gnt_cnt == 2'h1);
      if (i_pwr_req)
        gnt_cnt <= 2'h2;
      else if (gnt_cnt != 2'h0)
        gnt_cnt <= gnt_cnt - 2'h1;
    end
  end
endmodule

// >>> bench/tb_top.sv
// self-checking bench for the identification frame builder
`timescale 1ns/10ps
`include "sifb_defines.vh"
module tb_top;
  reg i_clk, i_nrst, i_wr, i_rd, i_phy_reset_done, i_link_reset;
  reg i_in_connection, i_break_rx, i_other_phy_req, i_in_low_power;
  reg stall, answer;
  reg [7:0] i_addr;
  reg [31:0] i_wdata, rd_val;
  reg [3:0] i_reset_reason;
  wire [31:0] o_rdata, o_tx_data;
  wire o_tx_valid, o_tx_sof, o_tx_eof, o_id_timeout, o_cominit_req;
  wire o_break_reply_tx, o_pwr_req_tx, o_pwr_done_tx, o_pwr_ack_tx;
  wire o_lp_exit_req, o_slumber_en, o_partial_en, o_com_only, rdy, fid, gnt;
  integer errors, n_checks, cyc, k, base, n_init, n_req, n_done, n_ack, n_brk;
  integer n_tmo;
  reg [31:0] w [0:7];
  sifb_frame_builder #(.ID_CYCLES(18'h14)) u_dut (.i_clk, .i_nrst, .i_addr,
    .i_wdata, .i_wr, .i_rd, .o_rdata, .i_phy_reset_done, .i_link_reset,
    .i_reset_reason, .i_in_connection, .i_tx_ready(rdy), .o_tx_valid,
    .o_tx_data, .o_tx_sof, .o_tx_eof, .i_far_identify(fid), .o_id_timeout,
    .o_cominit_req, .i_break_rx, .o_break_reply_tx, .i_pwr_grant_rx(gnt),
    .i_other_phy_req, .i_in_low_power, .o_pwr_req_tx, .o_pwr_done_tx,
    .o_pwr_ack_tx, .o_lp_exit_req, .o_slumber_en, .o_partial_en, .o_com_only);
  sifb_far_model u_far (.i_clk, .i_nrst, .i_stall(stall), .i_answer(answer),
    .i_tx_valid(o_tx_valid), .i_tx_data(o_tx_data), .i_tx_eof(o_tx_eof),
    .i_pwr_req(o_pwr_req_tx), .o_ready(rdy), .o_far_identify(fid),
    .o_grant(gnt));
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  // pulse tallies and a hang guard well above the expected run
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    n_init <= n_init + o_cominit_req;
    n_req <= n_req + o_pwr_req_tx;
    n_done <= n_done + o_pwr_done_tx;
    n_ack <= n_ack + o_pwr_ack_tx;
    n_brk <= n_brk + o_break_reply_tx;
    n_tmo <= n_tmo + o_id_timeout;
    if (cyc == 3000) begin
      errors = errors + 1;
      close_out;
    end
  end
  task check(input [63:0] nm, input [31:0] exp, input [31:0] got);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("MISMATCH %0s exp %h got %h", nm, exp, got);
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    begin
      @(posedge i_clk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_clk);
      i_wr <= 1'b0;
    end
  endtask
  // read data stand only in the cycle after the strobe
  task rd(input [7:0] a);
    begin
      @(posedge i_clk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1 rd_val = o_rdata;
    end
  endtask
  function [31:0] crc_w(input [31:0] c, input [31:0] d);
    integer b;
    begin
      crc_w = c;
      for (b = 31; b >= 0; b = b - 1)
        crc_w = {crc_w[30:0], 1'b0} ^
          ((crc_w[31] ^ d[b]) ? `SIFB_CRC_POLY : 32'h0);
    end
  endfunction
  // one frame after a link reset, held off by an open connection first
  task frame(input [7:0] ctl, input [3:0] rsn, input [3:0] ex, input an);
    reg [31:0] c;
    begin
      answer <= an;
      stall <= rsn[0];
      wr(`SIFB_A_CTRL, {24'h0, ctl});
      @(posedge i_clk);
      i_link_reset <= 1'b1;
      i_reset_reason <= rsn;
      i_in_connection <= 1'b1;
      @(posedge i_clk);
      i_link_reset <= 1'b0;
      i_phy_reset_done <= 1'b1;
      @(posedge i_clk);
      i_phy_reset_done <= 1'b0;
      repeat (5) @(posedge i_clk);
      #1 check("held", 0, o_tx_valid);
      i_in_connection <= 1'b0;
      for (k = 0; k < 60 && !(o_tx_eof && rdy); k = k + 1) begin
        @(posedge i_clk);
        #1;
      end
      @(posedge i_clk);
      #1;
      base = n_init;
      w[0] = {8'h10, 4'h0, ex, 16'h0008};
      w[1] = 32'h01234567;
      w[2] = 32'h89ABCDEF;
      w[3] = 32'h5A5A0001;
      w[4] = 32'hC3C3FFFE;
      c[7:0] = {1'b0, (ctl[1:0] == 2'h3) ? 2'h0 : ctl[1:0],
                ctl[2], ctl[3], 3'h1};
      w[5] = {8'h2D, c[7:0], 16'h0100};
      w[6] = 32'h0;
      c = `SIFB_CRC_INIT;
      for (k = 0; k < 7; k = k + 1)
        c = crc_w(c, w[k]);
      w[7] = ~c;
      check("w0", w[0], u_far.words[0]);
      check("w5", w[5], u_far.words[5]);
      for (k = 0; k < 8; k = k + 1)
        check("word", w[k], u_far.words[k]);
      repeat (40) @(posedge i_clk);
      #1 check("cominit", {31'h0, !an}, n_init - base);
      check("timeout", n_init, n_tmo);
      rd(`SIFB_A_STATUS);
      check("reason", {28'h0, ex}, {28'h0, rd_val[3:0]});
      $display("frame test done");
    end
  endtask
  task brk;
    begin
      @(posedge i_clk);
      i_break_rx <= 1'b1;
      repeat (2) @(posedge i_clk);
      i_break_rx <= 1'b0;
      repeat (2) @(posedge i_clk);
      #1 check("reply", 2, n_brk);
      $display("break test done");
    end
  endtask
  // consumer: blocked by another phy, leaves low power, then request
  task power;
    begin
      i_other_phy_req <= 1'b1;
      i_in_low_power <= 1'b1;
      wr(`SIFB_A_CTRL, 32'h1D);
      repeat (6) @(posedge i_clk);
      #1 check("req", 0, n_req);
      i_other_phy_req <= 1'b0;
      repeat (4) @(posedge i_clk);
      #1 check("exit", 1, o_lp_exit_req);
      check("com_only", 1, o_com_only);
      i_in_low_power <= 1'b0;
      repeat (10) @(posedge i_clk);
      #1 check("req", 1, n_req);
      check("com_only", 0, o_com_only);
      check("ack", 1, n_ack);
      check("slumber", 0, o_slumber_en);
      wr(`SIFB_A_CTRL, 32'h0D);
      repeat (3) @(posedge i_clk);
      #1 check("done", 1, n_done);
      check("slumber", 1, o_slumber_en);
      check("partial", 1, o_partial_en);
      wr(`SIFB_A_CTRL, 32'h10);
      repeat (10) @(posedge i_clk);
      #1 check("req", 1, n_req);
      $display("power test done");
    end
  endtask
  task close_out;
    begin
      $display("checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  initial begin
    {i_nrst, i_wr, i_rd, i_phy_reset_done, i_link_reset} = 5'h0;
    {i_in_connection, i_break_rx, i_other_phy_req, i_in_low_power} = 4'h0;
    {stall, answer, i_addr, i_wdata, i_reset_reason} = 46'h0;
    {errors, n_checks, cyc, n_init, n_req} = 160'h0;
    {n_done, n_ack, n_brk, n_tmo} = 128'h0;
    repeat (3) @(posedge i_clk);
    i_nrst <= 1'b1;
    rd(`SIFB_A_STATUS);
    check("status", 32'h110, rd_val);
    rd(8'h1C);
    check("unmapped", 0, rd_val);
    wr(`SIFB_A_NAME_HI, 32'h01234567);
    wr(`SIFB_A_NAME_LO, 32'h89ABCDEF);
    wr(`SIFB_A_ADDR_HI, 32'h5A5A0001);
    wr(`SIFB_A_ADDR_LO, 32'hC3C3FFFE);
    wr(`SIFB_A_PHY_ID, 32'h2D);
    frame(8'h0D, 4'h4, 4'h4, 1'b1);
    frame(8'h03, 4'h7, 4'h7, 1'b0);
    frame(8'h0D, 4'h5, 4'h7, 1'b1);
    frame(8'h05, 4'h2, 4'h2, 1'b1);
    frame(8'h0A, 4'h8, 4'h8, 1'b1);
    frame(8'h00, 4'h0, 4'h0, 1'b1);
    brk;
    power;
    close_out;
  end
endmodule

// >>> logic/sifb_crc.v
// crc step over one dword of the address frame
`timescale 1ns/10ps
`include "sifb_defines.vh"
module sifb_crc (
  input wire [31:0] i_crc,
  input wire [31:0] i_data,
  output wire [31:0] o_crc
);
  // one dword folded msb first, a 32 step shift unrolled by the tool
  function [31:0] step;
    input [31:0] c;
    input [31:0] d;
    integer k;
    reg [31:0] r;
    begin
      r = c;
      for (k = 31; k >= 0; k = k - 1) begin
        if (r[31] ^ d[k]) begin
          r = {r[30:0], 1'b0} ^ `SIFB_CRC_POLY;
        end else begin
          r = {r[30:0], 1'b0};
        end
      end
      step = r;
    end
  endfunction

  assign o_crc = step(i_crc, i_data);
endmodule

// >>> logic/sifb_defines.vh
// constants for the identification frame builder
`ifndef SIFB_DEFINES_VH
`define SIFB_DEFINES_VH
// register byte addresses
`define SIFB_A_CTRL 8'h00
`define SIFB_A_NAME_LO 8'h04
`define SIFB_A_NAME_HI 8'h08
`define SIFB_A_ADDR_LO 8'h0C
`define SIFB_A_ADDR_HI 8'h10
`define SIFB_A_PHY_ID 8'h14
`define SIFB_A_STATUS 8'h18
// control field positions
`define SIFB_C_PWR 1:0
`define SIFB_C_SLUMBER 2
`define SIFB_C_PARTIAL 3
`define SIFB_C_NEED 4
// power capable codes
`define SIFB_PWR_NONE 2'h0
`define SIFB_PWR_CONSUMER 2'h1
`define SIFB_PWR_SOURCE 2'h2
// fixed frame fields
`define SIFB_DEV_END 3'h1
`define SIFB_AFT_IDENT 4'h0
`define SIFB_INIT_BITS 3'h0
`define SIFB_TGT_BITS 3'h4
`define SIFB_PERSIST 1'h0
`define SIFB_ZONE_BITS 2'h0
`define SIFB_BRK_REPLY 1'h1
`define SIFB_PWR_DIS 1'h1
// reason codes
`define SIFB_RSN_POWER_ON 4'h0
`define SIFB_RSN_HARD 4'h2
`define SIFB_RSN_SYNC 4'h4
`define SIFB_RSN_BREAK 4'h7
`define SIFB_RSN_TEST 4'h8
// frame length and crc
`define SIFB_LAST_WORD 3'h7
`define SIFB_CRC_WORD 3'h7
`define SIFB_CRC_INIT 32'hFFFFFFFF
`define SIFB_CRC_POLY 32'h04C11DB7
// identify wait timer
// 1 ms of 4 ns cycles, sized to the timer width
`define SIFB_ID_CYCLES 18'h3D090
`define SIFB_TMR_W 18
`endif

// >>> logic/sifb_frame_builder.v
// identification address frame builder with power and break handling
//
// Implementation choices: the address map and the plain strobed port.
`timescale 1ns/10ps
`include "sifb_defines.vh"
// Summary of operation
// R1: frame starts only after the phy reset sequence reports done
// R2: byte 0 device type carries the end device code
// R3: byte 0 frame type is zero, an identification frame
// R4: all three initiator port bits in byte 2 are cleared
// R5: byte 3 advertises ssp target only
// R6: device name bytes 4-11, port address 12-19, phy id byte 20
// R7: reason nibble in byte 1 holds the link reset cause code
// R8: persistent connection capable bit is zero
// R9: both zoned domain bits in byte 21 are zero
// R10: power code 00 issues no power primitives and never acknowledges
// R11: power code 01 requests, reports done and acknowledges grants
// R12: code 10 is a source; 11 is reserved and never advertised
// R13: one phy at a time, leave low power before requesting
// R14: low power conditions held disabled while consuming extra power
// R15: slumber capable bit from control; slumber wakes only on com signals
// R16: partial capable bit from control; partial wakes only on com signals
// R17: break reply capable set; every break answered with break reply
// R18: power disable capable bit in byte 22 is set
// R19: frames are sent only outside connections
// R20: far identify must arrive within 1 ms else notify and reinit
// R21: reserved bits and bytes zero, crc over bytes 0-27 appended
// R22: latest legal link reset reason is latched for the next frame
module sifb_frame_builder #(
  parameter [`SIFB_TMR_W-1:0] ID_CYCLES = `SIFB_ID_CYCLES
) (
  input wire i_clk,
  input wire i_nrst,
  input wire [7:0] i_addr,
  input wire [31:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [31:0] o_rdata,
  input wire i_phy_reset_done,
  input wire i_link_reset,
  input wire [3:0] i_reset_reason,
  input wire i_in_connection,
  input wire i_tx_ready,
  output wire o_tx_valid,
  output reg [31:0] o_tx_data,
  output wire o_tx_sof,
  output wire o_tx_eof,
  input wire i_far_identify,
  output reg o_id_timeout,
  output reg o_cominit_req,
  input wire i_break_rx,
  output reg o_break_reply_tx,
  input wire i_pwr_grant_rx,
  input wire i_other_phy_req,
  input wire i_in_low_power,
  output reg o_pwr_req_tx,
  output reg o_pwr_done_tx,
  output reg o_pwr_ack_tx,
  output wire o_lp_exit_req,
  output wire o_slumber_en,
  output wire o_partial_en,
  output wire o_com_only
);
  // frame states
  localparam [2:0] F_IDLE = 3'b001;
  localparam [2:0] F_SEND = 3'b010;
  localparam [2:0] F_WAIT = 3'b100;
  // power consumer states
  localparam [3:0] P_IDLE = 4'b0001;
  localparam [3:0] P_EXIT = 4'b0010;
  localparam [3:0] P_REQ = 4'b0100;
  localparam [3:0] P_USE = 4'b1000;

  reg [4:0] ctrl_q;
  reg [63:0] name_q;
  reg [63:0] addr_q;
  reg [7:0] phy_id_q;
  reg [3:0] reason_q;
  reg [2:0] fst_q;
  reg [2:0] fst_d;
  reg [2:0] idx_q;
  reg [31:0] crc_q;
  reg [`SIFB_TMR_W-1:0] tmr_q;
  reg done_q;
  reg [3:0] pst_q;
  reg [3:0] pst_d;
  reg sent_q;
  wire [31:0] crc_nx;
  wire [1:0] pwr_cap;
  wire start;
  wire fire;
  wire [2:0] sel;
  wire consumer;
  reg [31:0] word;

  // reserved power code 11 falls back to none so it is never sent
  assign pwr_cap = (ctrl_q[`SIFB_C_PWR] == `SIFB_PWR_CONSUMER ||
                    ctrl_q[`SIFB_C_PWR] == `SIFB_PWR_SOURCE) ?
                   ctrl_q[`SIFB_C_PWR] : `SIFB_PWR_NONE; // [R12]
  assign consumer = (pwr_cap == `SIFB_PWR_CONSUMER); // [R10] [R11]

  // legal reason codes only; others are reserved and ignored
  function valid_reason;
    input [3:0] r;
    begin
      case (r)
        `SIFB_RSN_POWER_ON, `SIFB_RSN_HARD, `SIFB_RSN_SYNC,
        `SIFB_RSN_BREAK, `SIFB_RSN_TEST: valid_reason = 1'b1;
        default: valid_reason = 1'b0;
      endcase
    end
  endfunction

  // halfword picker over a 64 bit identifier, msb first on the wire
  function [15:0] hw_pick;
    input [63:0] v;
    input [1:0] h;
    begin
      case (h)
        2'h0: hw_pick = v[63:48];
        2'h1: hw_pick = v[47:32];
        2'h2: hw_pick = v[31:16];
        default: hw_pick = v[15:0];
      endcase
    end
  endfunction

  // register writes; reason follows each link reset that carries a legal code
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ctrl_q <= 5'h00;
      name_q <= 64'h0000000000000000;
      addr_q <= 64'h0000000000000000;
      phy_id_q <= 8'h00;
      reason_q <= `SIFB_RSN_POWER_ON;
    end else begin
      if (i_wr) begin
        case (i_addr)
          `SIFB_A_CTRL: ctrl_q <= i_wdata[4:0];
          `SIFB_A_NAME_LO: name_q[31:0] <= i_wdata;
          `SIFB_A_NAME_HI: name_q[63:32] <= i_wdata;
          `SIFB_A_ADDR_LO: addr_q[31:0] <= i_wdata;
          `SIFB_A_ADDR_HI: addr_q[63:32] <= i_wdata;
          `SIFB_A_PHY_ID: phy_id_q <= i_wdata[7:0];
          default: ;
        endcase
      end
      if (i_link_reset && valid_reason(i_reset_reason)) begin
        reason_q <= i_reset_reason; // [R22] [R7]
      end
    end
  end

  // read data the cycle after the strobe; unmapped reads zero
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rdata <= 32'h00000000;
    end else if (i_rd) begin
      case (i_addr)
        `SIFB_A_CTRL: o_rdata <= {27'h0000000, ctrl_q};
        `SIFB_A_NAME_LO: o_rdata <= name_q[31:0];
        `SIFB_A_NAME_HI: o_rdata <= name_q[63:32];
        `SIFB_A_ADDR_LO: o_rdata <= addr_q[31:0];
        `SIFB_A_ADDR_HI: o_rdata <= addr_q[63:32];
        `SIFB_A_PHY_ID: o_rdata <= {24'h000000, phy_id_q};
        `SIFB_A_STATUS: o_rdata <= {20'h00000, pst_q, sent_q,
                                    fst_q, reason_q};
        default: o_rdata <= 32'h00000000;
      endcase
    end else begin
      o_rdata <= 32'h00000000;
    end
  end

  // frame dword mux: fixed fields, identifiers, reserved zero
  always @* begin
    word = 32'h00000000;
    case (sel)
      3'h0: word = {1'b0, `SIFB_DEV_END, `SIFB_AFT_IDENT, // [R2] [R3]
                    4'h0, reason_q, // [R7]
                    4'h0, `SIFB_INIT_BITS, 1'b0, // [R4]
                    4'h0, `SIFB_TGT_BITS, 1'b0}; // [R5]
      3'h1: word = {hw_pick(name_q, 2'h0), hw_pick(name_q, 2'h1)}; // [R6]
      3'h2: word = {hw_pick(name_q, 2'h2), hw_pick(name_q, 2'h3)};
      3'h3: word = {hw_pick(addr_q, 2'h0), hw_pick(addr_q, 2'h1)};
      3'h4: word = {hw_pick(addr_q, 2'h2), hw_pick(addr_q, 2'h3)};
      3'h5: word = {phy_id_q, // [R6]
                    `SIFB_PERSIST, pwr_cap, // [R8] [R12]
                    ctrl_q[`SIFB_C_SLUMBER], // [R15]
                    ctrl_q[`SIFB_C_PARTIAL], // [R16]
                    `SIFB_ZONE_BITS, `SIFB_BRK_REPLY, // [R9] [R17]
                    7'h00, `SIFB_PWR_DIS, 8'h00}; // [R18] [R21]
      3'h6: word = 32'h00000000; // [R21]
      default: word = ~crc_nx; // [R21]
    endcase
  end

  // crc folds the dword on the wire, so stalls cannot fold it twice
  sifb_crc u_crc (
    .i_crc (crc_q),
    .i_data (o_tx_data),
    .o_crc (crc_nx)
  );

  // a completed phy reset arms one frame; held off inside connections
  // a link reset in the same cycle wins, so no frame leaves before the
  // new phy reset sequence has finished
  assign start = done_q && !i_in_connection && !i_link_reset; // [R1] [R19]
  assign o_tx_valid = (fst_q == F_SEND);
  assign o_tx_sof = o_tx_valid && (idx_q == 3'h0);
  assign o_tx_eof = o_tx_valid && (idx_q == `SIFB_LAST_WORD);
  assign fire = o_tx_valid && i_tx_ready;
  // the dword register loads one index ahead on a taken word, so it
  // always shows the word at idx_q while it waits for the sink
  assign sel = fire ? idx_q + 3'h1 : idx_q;

  // frame state transitions
  always @* begin
    fst_d = fst_q;
    case (fst_q)
      F_IDLE: if (start) fst_d = F_SEND;
      F_SEND: if (fire && idx_q == `SIFB_LAST_WORD) fst_d = F_WAIT;
      F_WAIT: begin
        if (i_far_identify || i_link_reset ||
            tmr_q == ID_CYCLES - 1'b1) begin
          fst_d = F_IDLE; // [R20]
        end
      end
      default: fst_d = F_IDLE;
    endcase
  end

  // frame sequencing, crc accumulation and identify wait timer
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      fst_q <= F_IDLE;
      idx_q <= 3'h0;
      crc_q <= `SIFB_CRC_INIT;
      tmr_q <= {`SIFB_TMR_W{1'b0}};
      done_q <= 1'b0;
      sent_q <= 1'b0;
      o_tx_data <= 32'h00000000;
      o_id_timeout <= 1'b0;
      o_cominit_req <= 1'b0;
    end else begin
      fst_q <= fst_d;
      o_id_timeout <= 1'b0;
      o_cominit_req <= 1'b0;
      // done is a level; a new link reset clears it until re-reported
      if (i_link_reset) begin
        done_q <= 1'b0;
        sent_q <= 1'b0;
      end else if (i_phy_reset_done && !sent_q) begin
        done_q <= 1'b1; // [R1]
      end
      if (fst_q == F_IDLE && start) begin
        done_q <= 1'b0;
        sent_q <= 1'b1;
      end
      // data word loads freely outside a frame, only when taken inside one, so a stall holds it
      if (fst_q != F_SEND || fire) begin
        o_tx_data <= word;
      end
      if (fire) begin
        idx_q <= idx_q + 3'h1;
        if (idx_q == `SIFB_LAST_WORD) begin
          idx_q <= 3'h0;
          crc_q <= `SIFB_CRC_INIT;
        end else begin
          crc_q <= crc_nx; // [R21]
        end
      end
      if (fst_q == F_WAIT) begin
        tmr_q <= tmr_q + 1'b1;
        if (fst_d == F_IDLE && !i_far_identify && !i_link_reset) begin
          o_id_timeout <= 1'b1; // [R20]
          o_cominit_req <= 1'b1; // [R20]
        end
      end else begin
        tmr_q <= {`SIFB_TMR_W{1'b0}};
      end
    end
  end

  // break answered one cycle later, regardless of frame state
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_break_reply_tx <= 1'b0;
    end else begin
      o_break_reply_tx <= i_break_rx; // [R17]
    end
  end

  // power consumer sequencing
  always @* begin
    pst_d = pst_q;
    case (pst_q)
      P_IDLE: begin
        if (consumer && ctrl_q[`SIFB_C_NEED] && !i_other_phy_req) begin
          pst_d = i_in_low_power ? P_EXIT : P_REQ; // [R13]
        end
      end
      P_EXIT: begin
        if (!consumer) pst_d = P_IDLE;
        else if (!i_in_low_power) pst_d = P_REQ; // [R13]
      end
      P_REQ: begin
        if (!consumer) pst_d = P_IDLE;
        else if (i_pwr_grant_rx) pst_d = P_USE;
      end
      P_USE: begin
        if (!consumer || !ctrl_q[`SIFB_C_NEED]) pst_d = P_IDLE;
      end
      default: pst_d = P_IDLE;
    endcase
  end

  // primitive pulses: request on entry, done on release, ack grants
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pst_q <= P_IDLE;
      o_pwr_req_tx <= 1'b0;
      o_pwr_done_tx <= 1'b0;
      o_pwr_ack_tx <= 1'b0;
    end else begin
      pst_q <= pst_d;
      o_pwr_req_tx <= consumer && pst_d == P_REQ &&
                      pst_q != P_REQ; // [R11] [R10]
      o_pwr_done_tx <= consumer && pst_q == P_USE &&
                       pst_d == P_IDLE; // [R11] [R10]
      o_pwr_ack_tx <= consumer && i_pwr_grant_rx; // [R11] [R10]
    end
  end

  // low power conditions masked while extra power is in use
  assign o_lp_exit_req = (pst_q == P_EXIT); // [R13]
  assign o_slumber_en = ctrl_q[`SIFB_C_SLUMBER] &&
                        pst_q != P_USE && pst_q != P_REQ; // [R14] [R15]
  assign o_partial_en = ctrl_q[`SIFB_C_PARTIAL] &&
                        pst_q != P_USE && pst_q != P_REQ; // [R14] [R16]
  // in slumber or partial only com signals are acted upon
  assign o_com_only = i_in_low_power; // [R15] [R16]
endmodule
